// File: common/nest_defs.svh
/*
 * constants of the nesting and standby controller: register offset, fields,
 * reset values, settle codes and wait lengths in main-clock periods.
 * assumes inclusion by bare name from design files.
 */
`ifndef NEST_DEFS_SVH
`define NEST_DEFS_SVH

`define OSC_WAIT_SEL_ADDR 16'hfffa
`define OSC_WAIT_SEL_RESET 8'h04
`define OSC_WAIT_SEL_MASK 8'h07
`define SETTLE_CODE_2P12 3'h0
`define SETTLE_CODE_2P14 3'h1
`define SETTLE_CODE_2P15 3'h2
`define SETTLE_CODE_2P16 3'h3
`define SETTLE_CODE_2P17 3'h4
`define SETTLE_CNT_W 18
`define SETTLE_2P12 18'h01000
`define SETTLE_2P14 18'h04000
`define SETTLE_2P15 18'h08000
`define SETTLE_2P16 18'h10000
`define SETTLE_2P17 18'h20000

`endif

// File: common/nest_pkg.sv
/*
 * types of the nesting and standby controller.
 * assumes nest_defs.svh supplies all numeric constants.
 */
package nest_pkg;

    typedef enum logic [3:0] {
        PWR_RUN = 4'b0001,
        PWR_HALT = 4'b0010,
        PWR_STOP = 4'b0100,
        PWR_SETTLE = 4'b1000
    } pwr_state_e;

    typedef enum logic [2:0] {
        SVC_NONE = 3'b001,
        SVC_NMI = 3'b010,
        SVC_TRAP = 3'b100
    } svc_kind_e;

endpackage : nest_pkg

// File: logic/nest_standby_ctrl.sv
/*
 * nested interrupt acceptance and standby control beside the cpu sequencer.
 * assumes sources present level request flags, the sequencer reports each
 * retired instruction with its class, and the main clock oscillator obeys
 * OSC_RUN_O and reports OSC_STABLE_I once oscillating again.
 */
// How it works
// (R01) maskable nesting needs accept enable flag set
// (R02) any acknowledge clears the accept enable flag
// (R03) equal or higher level nests, lower waits
// (R04) refused requests stay pending, taken after return
// (R05) nothing nests inside non-maskable service
// (R06) level flag 0: only nmi and high-level nest
// (R07) level flag 1 or trap: both levels nest
// (R08) level select 0 high, 1 low
// (R09) hold instructions defer acknowledge one instruction
// (R10) trap instruction never defers acknowledge
// (R11) request flags latch regardless of level select
// (R12) halt gates cpu clock, oscillator keeps running
// (R13) stop halts the main oscillator
// (R14) standby keeps registers and port latches unchanged
// (R15) stop exit by interrupt waits settling time
// (R16) settle code picks 2^12..2^17 main periods
// (R17) wait select resets 04h, upper bits zero
// (R18) settle count starts only when oscillator runs
// (R19) maskable acknowledge copies level into level flag
// (R20) halt exit: vector if enabled, else continue
// (R21) settle counter releases cpu clock at count
// (R22) trap service counts as level flag 1
`timescale 1ns/1ps
`include "nest_defs.svh"

module nest_standby_ctrl (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] REQ_FLAG_I,
    input wire logic [7:0] MASK_FLAG_I,
    input wire logic [7:0] LEVEL_SELECT_I,
    input wire logic NMI_REQ_I,
    input wire logic INSTR_DONE_I,
    input wire logic HOLD_INSTR_I,
    input wire logic TRAP_INSTR_I,
    input wire logic RETURN_FROM_INTERRUPT_INSTR_INSTR_I,
    input wire logic RETURN_FROM_TRAP_INSTR_INSTR_I,
    input wire logic ACCEPT_ON_I,
    input wire logic MASK_ALL_I,
    input wire logic HALT_INSTR_I,
    input wire logic STOP_INSTR_I,
    input wire logic STATUS_WR_I,
    input wire logic [1:0] STATUS_WR_DATA_I,
    input wire logic OSC_STABLE_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    output logic ACK_O,
    output logic ACK_NMI_O,
    output logic [2:0] ACK_SOURCE_O,
    output logic RESUME_NEXT_O,
    output logic ACCEPT_ENABLE_FLAG_O,
    output logic IN_SERVICE_LEVEL_FLAG_O,
    output logic CPU_CLK_EN_O,
    output logic OSC_RUN_O,
    output logic [3:0] PWR_STATE_O
);

    ////////////////////////////////////////////////////////////////////
    // state

    logic accept_enable_flag;
    logic in_service_level_flag;
    logic [7:0] oscillation_wait_select;
    nest_pkg::svc_kind_e svc_kind;
    nest_pkg::pwr_state_e pwr_state;
    nest_pkg::pwr_state_e next_pwr_state;
    logic hold_pending;
    logic after_return;
    logic [`SETTLE_CNT_W-1:0] settle_cnt;
    logic [`SETTLE_CNT_W-1:0] settle_target;
    logic nmi_latched;

    ////////////////////////////////////////////////////////////////////
    // arbitration

    wire [7:0] live_req = REQ_FLAG_I & ~MASK_FLAG_I;
    wire [7:0] high_req = live_req & ~LEVEL_SELECT_I; // R08
    wire [7:0] low_req = live_req & LEVEL_SELECT_I; // R08
    wire [7:0] pick_set = (|high_req) ? high_req : low_req;
    logic [2:0] pick_idx;
    always_comb begin
        pick_idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pick_set[i]) begin
                pick_idx = 3'(i);
            end
        end
    end

    wire in_nmi = (svc_kind == nest_pkg::SVC_NMI);
    wire in_trap = (svc_kind == nest_pkg::SVC_TRAP);
    wire level_open = in_service_level_flag | in_trap; // R07 R22
    wire high_ok = (|high_req) & accept_enable_flag; // R01 R03 R06
    wire low_ok = (|low_req) & accept_enable_flag & level_open; // R03 R07
    wire nmi_ok = (nmi_latched | NMI_REQ_I) & ~in_nmi; // R05
    wire mask_ok = (high_ok | low_ok) & ~in_nmi; // R05
    wire [7:0] picked_mask = (high_ok ? high_req : low_req) & pick_set;

    // acknowledge only at an instruction boundary, never right behind a
    // hold instruction or the first instruction after a return
    wire boundary = INSTR_DONE_I & ~HOLD_INSTR_I & ~hold_pending & ~after_return; // R09 R04
    wire running = (pwr_state == nest_pkg::PWR_RUN);
    wire take_nmi = running & boundary & nmi_ok;
    wire take_mask = running & boundary & ~nmi_ok & mask_ok & (|picked_mask);
    wire take_any = take_nmi | take_mask;

    ////////////////////////////////////////////////////////////////////
    // standby

    wire wake_req = (|live_req) | NMI_REQ_I;
    wire halt_vector = NMI_REQ_I | mask_ok; // R20
    wire [2:0] settle_code = oscillation_wait_select[2:0];

    assign settle_target = (settle_code == `SETTLE_CODE_2P12) ? `SETTLE_2P12 :
        (settle_code == `SETTLE_CODE_2P14) ? `SETTLE_2P14 :
        (settle_code == `SETTLE_CODE_2P15) ? `SETTLE_2P15 :
        (settle_code == `SETTLE_CODE_2P16) ? `SETTLE_2P16 : `SETTLE_2P17; // R16

    always_comb begin
        next_pwr_state = pwr_state;
        case (pwr_state)
            nest_pkg::PWR_RUN: begin
                if (INSTR_DONE_I && STOP_INSTR_I) begin
                    next_pwr_state = wake_req ? nest_pkg::PWR_SETTLE : nest_pkg::PWR_STOP;
                end else if (INSTR_DONE_I && HALT_INSTR_I) begin
                    next_pwr_state = nest_pkg::PWR_HALT; // R12
                end
            end
            nest_pkg::PWR_HALT: begin
                if (wake_req) begin
                    next_pwr_state = nest_pkg::PWR_RUN; // R20
                end
            end
            nest_pkg::PWR_STOP: begin
                if (wake_req) begin
                    next_pwr_state = nest_pkg::PWR_SETTLE; // R15
                end
            end
            nest_pkg::PWR_SETTLE: begin
                if (settle_cnt == settle_target) begin
                    next_pwr_state = nest_pkg::PWR_RUN; // R21
                end
            end
            default: next_pwr_state = nest_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            pwr_state <= nest_pkg::PWR_RUN;
            settle_cnt <= '0;
            RESUME_NEXT_O <= 1'b0;
        end else begin
            pwr_state <= next_pwr_state;
            // count only once the oscillator reports it runs again
            if (pwr_state != nest_pkg::PWR_SETTLE) begin
                settle_cnt <= '0;
            end else if (OSC_STABLE_I) begin
                settle_cnt <= settle_cnt + 1'b1; // R18 R21
            end
            RESUME_NEXT_O <= (pwr_state != nest_pkg::PWR_RUN)
                && (next_pwr_state == nest_pkg::PWR_RUN) && !halt_vector; // R20
        end
    end

    // cpu clock gated in every standby state, registers simply hold
    assign CPU_CLK_EN_O = running; // R12 R14
    assign OSC_RUN_O = (pwr_state != nest_pkg::PWR_STOP); // R13

    ////////////////////////////////////////////////////////////////////
    // status word flags and service tracking

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            accept_enable_flag <= 1'b0;
            in_service_level_flag <= 1'b1;
            svc_kind <= nest_pkg::SVC_NONE;
            hold_pending <= 1'b0;
            after_return <= 1'b0;
            nmi_latched <= 1'b0;
        end else begin
            // a second nmi during nmi service collapses into one pending
            if (take_nmi) begin
                nmi_latched <= 1'b0;
            end else if (NMI_REQ_I) begin
                nmi_latched <= 1'b1; // R04
            end
            if (INSTR_DONE_I) begin
                hold_pending <= HOLD_INSTR_I & ~TRAP_INSTR_I; // R09 R10
                after_return <= RETURN_FROM_INTERRUPT_INSTR_INSTR_I | RETURN_FROM_TRAP_INSTR_INSTR_I; // R04
            end
            if (take_any || (INSTR_DONE_I && TRAP_INSTR_I)) begin
                accept_enable_flag <= 1'b0; // R02 R10
            end else if (INSTR_DONE_I && ACCEPT_ON_I) begin
                accept_enable_flag <= 1'b1;
            end else if (INSTR_DONE_I && MASK_ALL_I) begin
                accept_enable_flag <= 1'b0;
            end else if (STATUS_WR_I) begin
                accept_enable_flag <= STATUS_WR_DATA_I[1];
            end
            if (take_nmi) begin
                in_service_level_flag <= 1'b0;
                svc_kind <= nest_pkg::SVC_NMI;
            end else if (take_mask) begin
                in_service_level_flag <= high_ok ? 1'b0 : 1'b1; // R19
                svc_kind <= nest_pkg::SVC_NONE;
            end else if (INSTR_DONE_I && TRAP_INSTR_I) begin
                svc_kind <= nest_pkg::SVC_TRAP;
            end else if (INSTR_DONE_I && (RETURN_FROM_INTERRUPT_INSTR_INSTR_I || RETURN_FROM_TRAP_INSTR_INSTR_I)) begin
                svc_kind <= nest_pkg::SVC_NONE;
                in_service_level_flag <= STATUS_WR_DATA_I[0];
            end else if (STATUS_WR_I) begin
                in_service_level_flag <= STATUS_WR_DATA_I[0];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            ACK_O <= 1'b0;
            ACK_NMI_O <= 1'b0;
            ACK_SOURCE_O <= 3'h0;
        end else begin
            ACK_O <= take_any;
            ACK_NMI_O <= take_nmi;
            ACK_SOURCE_O <= take_mask ? pick_idx : 3'h0; // R11
        end
    end

    assign ACCEPT_ENABLE_FLAG_O = accept_enable_flag;
    assign IN_SERVICE_LEVEL_FLAG_O = in_service_level_flag;
    assign PWR_STATE_O = pwr_state;

    ////////////////////////////////////////////////////////////////////
    // settle code register

    wire wait_sel_hit = (REG_ADDR_I == `OSC_WAIT_SEL_ADDR);
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            oscillation_wait_select <= `OSC_WAIT_SEL_RESET; // R17
        end else if (REG_WR_I && wait_sel_hit) begin
            oscillation_wait_select <= REG_WDATA_I & `OSC_WAIT_SEL_MASK; // R17
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O <= 8'h00;
        end else begin
            REG_RDATA_O <= wait_sel_hit ? oscillation_wait_select : 8'h00;
        end
    end

endmodule : nest_standby_ctrl

// File: verif/nest_props.sv
/* assertions on the ports of the nesting and standby controller.
   assumes the core clock also times the settling wait; bound below. */
`timescale 1ns/1ps
`include "nest_defs.svh"
module nest_props (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] LEVEL_SELECT_I,
    input wire logic INSTR_DONE_I,
    input wire logic HOLD_INSTR_I,
    input wire logic RETURN_FROM_INTERRUPT_INSTR_INSTR_I,
    input wire logic OSC_STABLE_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic ACK_O,
    input wire logic ACK_NMI_O,
    input wire logic [2:0] ACK_SOURCE_O,
    input wire logic ACCEPT_ENABLE_FLAG_O,
    input wire logic IN_SERVICE_LEVEL_FLAG_O,
    input wire logic CPU_CLK_EN_O,
    input wire logic OSC_RUN_O,
    input wire logic [3:0] PWR_STATE_O
);
    logic [7:0] lvl_q;
    logic [2:0] code_q;
    logic [17:0] cnt;
    logic defer_q;
    logic nmi_q;
    wire settle = PWR_STATE_O == nest_pkg::PWR_SETTLE;
    // prohibited codes fall back to the longest wait
    wire [17:0] tgt = code_q == 3'h0 ? `SETTLE_2P12 : code_q == 3'h1 ? `SETTLE_2P14 :
        code_q == 3'h2 ? `SETTLE_2P15 : code_q == 3'h3 ? `SETTLE_2P16 : `SETTLE_2P17;
    always_ff @(posedge CORE_CLK_I) begin
        lvl_q <= LEVEL_SELECT_I;
        cnt <= !settle ? 18'h0 : (OSC_STABLE_I ? cnt + 18'h1 : cnt);
        if (!RESET_N_I) begin
            code_q <= 3'h4;
            defer_q <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            if (REG_WR_I && REG_ADDR_I == `OSC_WAIT_SEL_ADDR)
                code_q <= REG_WDATA_I[2:0];
            if (INSTR_DONE_I)
                defer_q <= HOLD_INSTR_I;
            nmi_q <= ACK_NMI_O || (nmi_q && !(INSTR_DONE_I && RETURN_FROM_INTERRUPT_INSTR_INSTR_I));
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    mask_gate_a: assert property (ACK_O && !ACK_NMI_O |-> $past(ACCEPT_ENABLE_FLAG_O))
        else $error("maskable acknowledge with enable flag clear");
    ack_clears_a: assert property (ACK_O |-> !ACCEPT_ENABLE_FLAG_O)
        else $error("enable flag still set after acknowledge");
    level_copy_a: assert property (ACK_O && !ACK_NMI_O
        |-> IN_SERVICE_LEVEL_FLAG_O == lvl_q[ACK_SOURCE_O]) else $error("level flag not copied");
    nmi_no_nest_a: assert property (nmi_q |-> !ACK_O)
        else $error("acknowledge inside nmi service");
    hold_defer_a: assert property (INSTR_DONE_I && (defer_q || HOLD_INSTR_I) |=> !ACK_O)
        else $error("acknowledge not deferred");
    halt_clock_a: assert property (PWR_STATE_O == nest_pkg::PWR_HALT
        |-> !CPU_CLK_EN_O && OSC_RUN_O) else $error("halt clocks wrong");
    stop_osc_a: assert property (OSC_RUN_O == (PWR_STATE_O != nest_pkg::PWR_STOP))
        else $error("oscillator run wrong");
    run_clock_a: assert property (CPU_CLK_EN_O == (PWR_STATE_O == nest_pkg::PWR_RUN))
        else $error("cpu clock enable wrong");
    settle_hold_a: assert property (settle && !OSC_STABLE_I |=> settle)
        else $error("settling left before oscillation");
    settle_len_a: assert property (PWR_STATE_O == nest_pkg::PWR_RUN && $past(settle)
        |-> cnt + 18'h1 >= tgt && cnt <= tgt + 18'h1) else $error("settling length wrong");
    upper_zero_a: assert property (REG_RDATA_O[7:3] == 5'h0)
        else $error("wait select upper bits set");
endmodule : nest_props
bind nest_standby_ctrl nest_props i_props (.*);

// File: verif/nest_standby_ctrl_test.sv
/* directed bench for the nesting and standby controller.
   assumes the checker is bound and the oscillator model drives stable. */
`timescale 1ns/1ps
`include "nest_defs.svh"
module nest_standby_ctrl_test;
    logic clk = 1'b0, rst_n = 1'b0, nmi = 1'b0, done = 1'b0, wr = 1'b0;
    logic [7:0] req = 8'h0a, lvl = 8'h02, wdata = 8'h00, rdata;
    logic [5:0] cls = 6'h00;
    logic [1:0] swd = 2'b11;
    logic trap = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic ack, ackn, resume, en_f, lv_f, cpuen, oscrun, stable;
    logic [2:0] src;
    logic [3:0] st;
    int n_errors = 0, n_compared = 0, n;
    initial begin
        forever #5 clk = ~clk;
    end
    osc_model i_osc (.clk_i(clk), .run_i(oscrun), .stable_o(stable));
    // class bits: hold, return, accept on, mask all, halt, stop
    nest_standby_ctrl i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REQ_FLAG_I(req),
        .MASK_FLAG_I(8'h00), .LEVEL_SELECT_I(lvl), .NMI_REQ_I(nmi), .INSTR_DONE_I(done),
        .HOLD_INSTR_I(cls[5]), .TRAP_INSTR_I(trap), .RETURN_FROM_INTERRUPT_INSTR_INSTR_I(cls[4]),
        .RETURN_FROM_TRAP_INSTR_INSTR_I(1'b0), .ACCEPT_ON_I(cls[3]), .MASK_ALL_I(cls[2]),
        .HALT_INSTR_I(cls[1]), .STOP_INSTR_I(cls[0]), .STATUS_WR_I(cls[4]),
        .STATUS_WR_DATA_I(swd), .OSC_STABLE_I(stable), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ACK_O(ack), .ACK_NMI_O(ackn),
        .ACK_SOURCE_O(src), .RESUME_NEXT_O(resume), .ACCEPT_ENABLE_FLAG_O(en_f),
        .IN_SERVICE_LEVEL_FLAG_O(lv_f), .CPU_CLK_EN_O(cpuen), .OSC_RUN_O(oscrun),
        .PWR_STATE_O(st));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [17:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("mismatches %0d of %0d compared", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic instr(input logic [5:0] c, input logic e);
        @(posedge clk);
        done <= 1'b1;
        cls <= c;
        @(posedge clk);
        done <= 1'b0;
        cls <= 6'h00;
        #1 check("ack", ack, e);
    endtask : instr
    task automatic rreg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 check("rdata", rdata, e);
    endtask : rreg
    task automatic wait_run(input logic [3:0] s, input int lim);
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == lim) begin
            n_errors++;
            final_report();
        end
    endtask : wait_run
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rreg(`OSC_WAIT_SEL_ADDR, `OSC_WAIT_SEL_RESET);
        instr(6'h00, 1'b0);
        instr(6'h28, 1'b0);
        instr(6'h00, 1'b0);
        instr(6'h00, 1'b1);
        check("source", src, 3'h3);
        check("level", lv_f, 1'b0);
        check("enable", en_f, 1'b0);
        req <= 8'h02;
        instr(6'h28, 1'b0);
        instr(6'h00, 1'b0);
        instr(6'h00, 1'b0);
        // trap while a high-level service holds level flag 0
        trap <= 1'b1;
        instr(6'h00, 1'b0);
        trap <= 1'b0;
        check("trap enable", en_f, 1'b0);
        instr(6'h28, 1'b0);
        instr(6'h00, 1'b0);
        instr(6'h00, 1'b1);
        check("trap source", src, 3'h1);
        instr(6'h30, 1'b0);
        instr(6'h00, 1'b0);
        instr(6'h00, 1'b1);
        check("source", src, 3'h1);
        nmi <= 1'b1;
        instr(6'h00, 1'b1);
        check("nmi", ackn, 1'b1);
        nmi <= 1'b0;
        instr(6'h28, 1'b0);
        instr(6'h00, 1'b0);
        instr(6'h00, 1'b0);
        req <= 8'h00;
        swd <= 2'b01;
        instr(6'h30, 1'b0);
        instr(6'h02, 1'b0);
        check("halt", {cpuen, oscrun, st}, {2'b01, nest_pkg::PWR_HALT});
        req <= 8'h01;
        wait_run(nest_pkg::PWR_RUN, 50);
        check("resume", {resume, ack}, 2'b10);
        req <= 8'h00;
        @(posedge clk);
        addr <= `OSC_WAIT_SEL_ADDR;
        wdata <= 8'hf8;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rreg(`OSC_WAIT_SEL_ADDR, 8'h00);
        rreg(16'hfff0, 8'h00);
        instr(6'h01, 1'b0);
        check("stop", {oscrun, st}, {1'b0, nest_pkg::PWR_STOP});
        req <= 8'h01;
        wait_run(nest_pkg::PWR_RUN, 6000);
        check("settle", n >= 4096, 1'b1);
        check("flags", {en_f, lv_f}, 2'b01);
        final_report();
    end
endmodule : nest_standby_ctrl_test

// File: verif/osc_model.sv
/* main oscillator stand-in: stable only some cycles after a restart.
   assumes run_i comes from the controller. */
`timescale 1ns/1ps
module osc_model #(parameter int START_DELAY = 20) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic stable_o
);
    int cnt = 0;
    // build-up delay makes the settle count start visibly late
    always @(posedge clk_i) begin
        cnt <= !run_i ? 0 : (cnt < START_DELAY ? cnt + 1 : cnt);
    end
    assign stable_o = run_i && cnt >= START_DELAY;
endmodule : osc_model
